// File: inc/tmon_pkg.sv
// Purpose: Shared constants and types for the temperature monitor register bank.
// Assumes: Registers are reached through read and write strobes from a serial engine.
// Notes: Read and write addresses differ for several registers, so both are named.
package tmon_pkg;
   // Register read and write addresses.
   localparam logic [7:0] STATUS_RD_ADDR = 8'h02;
   localparam logic [7:0] CONFIG_RD_ADDR = 8'h03;
   localparam logic [7:0] CONFIG_WR_ADDR = 8'h09;
   localparam logic [7:0] RATE_RD_ADDR = 8'h04;
   localparam logic [7:0] RATE_WR_ADDR = 8'h0a;
   localparam logic [7:0] FAULTQ_ADDR = 8'h22;

   // Reset values, masks of the writable bits and the mask of the latched status bits.
   localparam logic [7:0] CONFIG_RESET = 8'h08;
   localparam logic [7:0] CONFIG_RW_MASK = 8'hf4;
   localparam logic [7:0] RATE_RESET = 8'h06;
   localparam logic [7:0] RATE_RW_MASK = 8'h0f;
   localparam logic [7:0] FAULTQ_RESET = 8'h01;
   localparam logic [7:0] FAULTQ_RW_MASK = 8'hcf;
   localparam logic [7:0] STATUS_LATCH_MASK = 8'h7c;

   // Configuration field positions.
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_STANDBY_BIT = 6;
   localparam int CFG_ROLE_BIT = 5;
   localparam int CFG_BETA_BIT = 4;
   localparam int CFG_RANGE_BIT = 2;

   // Status field positions.
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_LOC_HI_BIT = 6;
   localparam int ST_LOC_LO_BIT = 5;
   localparam int ST_REM_HI_BIT = 4;
   localparam int ST_REM_LO_BIT = 3;
   localparam int ST_OPEN_BIT = 2;
   localparam int ST_REM_CRIT_BIT = 1;
   localparam int ST_LOC_CRIT_BIT = 0;

   // Fault queue register field positions.
   localparam int FQ_SCL_BIT = 7;
   localparam int FQ_SDA_BIT = 6;
   localparam int FQ_DEPTH_LSB = 1;

   // Timing: core clock rate, the millisecond tick and the conversion periods.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int MS_W = 14;
   localparam logic [3:0] RATE_MAX_CODE = 4'ha;
   localparam int unsigned PERIOD_MS [0:10] = '{16000, 8000, 4000, 2000, 1000, 500,
                                               250, 200, 100, 50, 27};
   localparam logic [2:0] FQ_MAX_COUNT = 3'h4;

   // Conversion sequencer states.
   typedef enum logic [0:0] {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;
endpackage : tmon_pkg

// File: hw/conv_rate_timer.sv
// Purpose: Periodic conversion request timer driven by the rate code.
// Assumes: A millisecond prescaler divides the core clock.
// Notes: Codes above the top rate are treated as the top rate.
`timescale 1ns/100ps
module conv_rate_timer #(
   parameter int unsigned TICK_CYCLES = tmon_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Control.
   input wire logic run,
   input wire logic [3:0] rate_code,
   // Request pulse, one cycle per period.
   output logic tick
);
   localparam int PRE_W = $clog2(TICK_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

   logic [PRE_W-1:0] pre_q, pre_d; // Cycles within the current millisecond.
   logic [tmon_pkg::MS_W-1:0] ms_q, ms_d; // Milliseconds within the period.
   logic [tmon_pkg::MS_W-1:0] lim; // Last millisecond of the period.
   logic [3:0] code_c; // Clamped rate code.

   // Stopping clears both counters, so a restart always waits a full period.
   always_comb begin
      code_c = (rate_code > tmon_pkg::RATE_MAX_CODE) ? tmon_pkg::RATE_MAX_CODE : rate_code;
      lim = tmon_pkg::MS_W'(tmon_pkg::PERIOD_MS[code_c] - 1);
      pre_d = pre_q;
      ms_d = ms_q;
      tick = 1'b0;
      if (!run) begin
         pre_d = '0;
         ms_d = '0;
      end else if (pre_q == PRE_LAST) begin
         pre_d = '0;
         // A shortened period takes effect at once, hence the compare by >=.
         if (ms_q >= lim) begin
            ms_d = '0;
            tick = 1'b1;
         end else begin
            ms_d = ms_q + 1'b1;
         end
      end else begin
         pre_d = pre_q + 1'b1;
      end
   end

   // Counter registers.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= '0;
         ms_q <= '0;
      end else begin
         pre_q <= pre_d;
         ms_q <= ms_d;
      end
   end

   // A request only comes at the end of the period of the current code.
   period_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
      tick |-> (pre_q == PRE_LAST) && (ms_q >= lim) && run)
      else $error("Conversion request off the period boundary.");
endmodule : conv_rate_timer

// File: hw/fault_queue.sv
// Purpose: Counts consecutive out-of-limit conversions before a flag may latch.
// Assumes: One sample pulse per finished conversion.
// Notes: The depth needed is one plus the number of ones in the depth field.
`timescale 1ns/100ps
module fault_queue (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Sample input.
   input wire logic sample,
   input wire logic out_of_limit,
   input wire logic [2:0] depth_field,
   // Qualification, valid in the sample cycle.
   output logic qualified
);
   logic [2:0] count_q, count_d; // Consecutive faults seen so far.
   logic [2:0] needed; // Faults required.
   logic [2:0] count_inc; // Count including this sample.

   // An in-limit sample breaks the run and restarts the count.
   always_comb begin
      needed = 3'h1 + {2'h0, depth_field[0]} + {2'h0, depth_field[1]}
               + {2'h0, depth_field[2]};
      count_inc = (count_q == tmon_pkg::FQ_MAX_COUNT) ? count_q : count_q + 1'b1;
      count_d = count_q;
      qualified = 1'b0;
      if (sample) begin
         if (out_of_limit) begin
            count_d = count_inc;
            qualified = (count_inc >= needed);
         end else begin
            count_d = '0;
         end
      end
   end

   // Count register.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // Qualification never comes before the required run length.
   depth_met_a: assert property (@(posedge core_clk) disable iff (!nrst)
      qualified |-> sample && out_of_limit && (count_inc >= needed))
      else $error("Fault qualified before the queue depth was reached.");
endmodule : fault_queue

// File: hw/temp_monitor_control_status_regs.sv
// Purpose: Configuration, rate, status and fault queue registers of a temperature monitor.
// Assumes: Serial engine gives strobes; front end and limit logic share core_clk.
// Notes: Alarm outputs are active low levels toward the open-drain pad drivers.
// Contract
// - Mask bit suppresses interrupt pin assertions.
// - Standby bit halts all conversions; a conversion already under way when it is set still runs to done.
// - Registers and outputs stay live in standby.
// - Standby limit writes re-evaluate stored measurements.
// - Role bit picks interrupt or second critical.
// - Bit 4 set disables beta cancellation.
// - Bit 2 selects extended measurement range.
// - Rate code sets conversion frequency, default 0110.
// - Each code maps to its fixed period.
// - Status busy bit shows conversion in progress.
// - Local high and low limit flags.
// - Remote high and low limit flags.
// - Open remote sensor sets its flag.
// - Critical flags follow trips, never interrupt.
// - Only bits six to two raise interrupt.
// - Latched flags clear on status read.
// - Bit 7 enables clock line timeout.
// - Bit 6 enables data line timeout.
// - Fault queue depth gates flag latching.
`timescale 1ns/100ps
module temp_monitor_control_status_regs #(
   parameter int unsigned TICK_CYCLES = tmon_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Register strobes from the serial engine.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Conversion front end.
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [7:0] local_temp,
   input wire logic [7:0] remote_temp,
   input wire logic remote_open,
   output logic beta_disable,
   output logic range_extended,
   // Limits held by the limit register block.
   input wire logic [7:0] local_high_lim,
   input wire logic [7:0] local_low_lim,
   input wire logic [7:0] remote_high_lim,
   input wire logic [7:0] remote_low_lim,
   input wire logic [7:0] local_crit_lim,
   input wire logic [7:0] remote_crit_lim,
   input wire logic limit_wr,
   // Bus timeout enables toward the serial engine.
   output logic scl_timeout_en,
   output logic sda_timeout_en,
   // Alarm outputs, active low.
   output logic critical_temp_output_n,
   output logic shared_out_n
);
   // Register state.
   logic [7:0] config_q, config_d; // Operating configuration.
   logic [7:0] rate_q, rate_d; // Sample rate select.
   logic [7:0] fq_q, fq_d; // Fault queue and timeout enables.
   logic [7:0] flags_q, flags_d; // Latched flags, bits six to two only.
   logic [7:0] rdata_q, rdata_d; // Read data.

   // Measurement and alarm state.
   logic [7:0] local_meas_q, local_meas_d; // Last local reading.
   logic [7:0] remote_meas_q, remote_meas_d; // Last remote reading.
   logic open_meas_q, open_meas_d; // Last open circuit result.
   logic local_crit_q, local_crit_d; // Local critical trip level.
   logic remote_crit_q, remote_crit_d; // Remote critical trip level.
   logic crit_n_q, crit_n_d; // Critical pin.
   logic shared_n_q, shared_n_d; // Shared pin.

   // Sequencer state.
   tmon_pkg::conv_state_t state_q, state_d;
   logic start_q, start_d; // Conversion request pulse.

   // Decoded controls and helpers.
   logic standby; // Conversions halted.
   logic alert_mask; // Interrupt suppressed.
   logic role_crit; // Shared pin acts as second critical output.
   logic status_rd; // Host reads the status register.
   logic tick; // Period elapsed.
   logic [7:0] src_local; // Local reading used for compares.
   logic [7:0] src_remote; // Remote reading used for compares.
   logic src_open; // Open circuit used for compares.
   logic [7:0] hit; // Limit compare results in status positions.
   logic qualified; // Fault queue met.
   logic [7:0] set_vec; // Flags set this cycle.
   logic [7:0] status_val; // Status as read.

   assign standby = config_q[tmon_pkg::CFG_STANDBY_BIT];
   assign alert_mask = config_q[tmon_pkg::CFG_MASK_BIT];
   assign role_crit = config_q[tmon_pkg::CFG_ROLE_BIT];
   assign status_rd = reg_rd && (reg_addr == tmon_pkg::STATUS_RD_ADDR);

   // Configuration bits go straight out to the front end and serial engine.
   assign beta_disable = config_q[tmon_pkg::CFG_BETA_BIT];
   assign range_extended = config_q[tmon_pkg::CFG_RANGE_BIT];
   assign scl_timeout_en = fq_q[tmon_pkg::FQ_SCL_BIT];
   assign sda_timeout_en = fq_q[tmon_pkg::FQ_SDA_BIT];
   assign conv_start = start_q;
   assign reg_rdata = rdata_q;
   assign critical_temp_output_n = crit_n_q;
   assign shared_out_n = shared_n_q;

   // Period timer, halted in standby.
   conv_rate_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .core_clk(core_clk),
      .nrst(nrst),
      .run(!standby),
      .rate_code(rate_q[3:0]),
      .tick(tick)
   );

   // Consecutive fault counter, fed by fresh conversion results only.
   fault_queue u_fq (
      .core_clk(core_clk),
      .nrst(nrst),
      .sample(conv_done),
      .out_of_limit(|hit),
      .depth_field(fq_q[3:1]),
      .qualified(qualified)
   );

   // Writable registers: only the documented bits are stored, the rest read zero.
   always_comb begin
      config_d = config_q;
      rate_d = rate_q;
      fq_d = fq_q;
      // Writes are accepted in standby just as in normal running.
      if (reg_wr) begin
         case (reg_addr)
            tmon_pkg::CONFIG_WR_ADDR: config_d = reg_wdata & tmon_pkg::CONFIG_RW_MASK;
            tmon_pkg::RATE_WR_ADDR: rate_d = reg_wdata & tmon_pkg::RATE_RW_MASK;
            tmon_pkg::FAULTQ_ADDR: fq_d = reg_wdata & tmon_pkg::FAULTQ_RW_MASK;
            default: config_d = config_q;
         endcase
      end
   end

   // The reset value of the reserved configuration bit is dropped by the mask.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         config_d_reset: config_q <= tmon_pkg::CONFIG_RESET & tmon_pkg::CONFIG_RW_MASK;
         rate_q <= tmon_pkg::RATE_RESET;
         fq_q <= tmon_pkg::FAULTQ_RESET;
      end else begin
         config_q <= config_d;
         rate_q <= rate_d;
         fq_q <= fq_d;
      end
   end

   // Conversion sequencer: a tick while busy is dropped rather than queued.
   always_comb begin
      state_d = state_q;
      start_d = 1'b0;
      case (state_q)
         tmon_pkg::CONV_IDLE: begin
            if (tick && !standby) begin
               start_d = 1'b1;
               state_d = tmon_pkg::CONV_BUSY;
            end
         end
         tmon_pkg::CONV_BUSY: begin
            // A conversion under way when standby is set is allowed to finish.
            if (conv_done) begin
               state_d = tmon_pkg::CONV_IDLE;
            end
         end
         default: state_d = tmon_pkg::CONV_IDLE;
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= tmon_pkg::CONV_IDLE;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
      end
   end

   // Compares use the fresh result on completion, else the stored one.
   always_comb begin
      src_local = conv_done ? local_temp : local_meas_q;
      src_remote = conv_done ? remote_temp : remote_meas_q;
      src_open = conv_done ? remote_open : open_meas_q;
      local_meas_d = src_local;
      remote_meas_d = src_remote;
      open_meas_d = src_open;
      hit = 8'h00;
      hit[tmon_pkg::ST_LOC_HI_BIT] = src_local > local_high_lim;
      hit[tmon_pkg::ST_LOC_LO_BIT] = src_local < local_low_lim;
      hit[tmon_pkg::ST_REM_HI_BIT] = src_remote > remote_high_lim;
      hit[tmon_pkg::ST_REM_LO_BIT] = src_remote < remote_low_lim;
      hit[tmon_pkg::ST_OPEN_BIT] = src_open;
      // Critical trips follow live limits, so limit writes act at once.
      local_crit_d = src_local > local_crit_lim;
      remote_crit_d = src_remote > remote_crit_lim;
   end

   // Flag latching: set wins over the clearing read in the same cycle.
   always_comb begin
      set_vec = 8'h00;
      if (conv_done && qualified) begin
         set_vec = hit;
      end else if (limit_wr && standby) begin
         set_vec = hit;
      end
      flags_d = ((status_rd ? 8'h00 : flags_q) | set_vec) & tmon_pkg::STATUS_LATCH_MASK;
      status_val = flags_q;
      status_val[tmon_pkg::ST_BUSY_BIT] = (state_q == tmon_pkg::CONV_BUSY);
      status_val[tmon_pkg::ST_REM_CRIT_BIT] = remote_crit_q;
      status_val[tmon_pkg::ST_LOC_CRIT_BIT] = local_crit_q;
   end

   // Pins: only latched flags drive the interrupt role, gated by the mask.
   always_comb begin
      crit_n_d = !(local_crit_q || remote_crit_q);
      if (role_crit) begin
         shared_n_d = crit_n_d;
      end else begin
         shared_n_d = !((|flags_q) && !alert_mask);
      end
   end

   // Read data, registered on the read strobe; unmapped reads return zero.
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            tmon_pkg::STATUS_RD_ADDR: rdata_d = status_val;
            tmon_pkg::CONFIG_RD_ADDR: rdata_d = config_q;
            tmon_pkg::RATE_RD_ADDR: rdata_d = rate_q;
            tmon_pkg::FAULTQ_ADDR: rdata_d = fq_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Measurement, flag, pin and read data registers; flags clear at reset and on a status read.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         local_meas_q <= 8'h00;
         remote_meas_q <= 8'h00;
         open_meas_q <= 1'b0;
         local_crit_q <= 1'b0;
         remote_crit_q <= 1'b0;
         flags_q <= 8'h00;
         crit_n_q <= 1'b1;
         shared_n_q <= 1'b1;
         rdata_q <= 8'h00;
      end else begin
         local_meas_q <= local_meas_d;
         remote_meas_q <= remote_meas_d;
         open_meas_q <= open_meas_d;
         local_crit_q <= local_crit_d;
         remote_crit_q <= remote_crit_d;
         flags_q <= flags_d;
         crit_n_q <= crit_n_d;
         shared_n_q <= shared_n_d;
         rdata_q <= rdata_d;
      end
   end

   // Checks on the register bank.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence status_read_s;
      reg_rd && (reg_addr == tmon_pkg::STATUS_RD_ADDR);
   endsequence

   sequence no_new_set_s;
      !conv_done && !limit_wr;
   endsequence

   mask_blocks_alert_a: assert property ((alert_mask && !role_crit) |=> shared_out_n)
      else $error("Interrupt pin asserted while masked.");

   standby_no_start_a: assert property (standby |=> !conv_start)
      else $error("Conversion started in standby.");

   role_crit_pin_a: assert property (
      (role_crit && (local_crit_q || remote_crit_q)) |=> !shared_out_n)
      else $error("Shared pin missed a critical trip.");

   busy_bit_a: assert property (conv_start |-> state_q == tmon_pkg::CONV_BUSY
      ##0 (status_val[tmon_pkg::ST_BUSY_BIT] && !conv_done) [*1] ##1 1'b1)
      else $error("Busy bit not set during conversion.");

   flag_latch_a: assert property (
      (flags_q[tmon_pkg::ST_LOC_HI_BIT] && !status_rd) |=> flags_q[tmon_pkg::ST_LOC_HI_BIT])
      else $error("Latched flag lost without a status read.");

   flag_clear_a: assert property ((status_read_s and no_new_set_s) |=> flags_q == 8'h00)
      else $error("Status read did not clear the latched flags.");

   crit_pin_a: assert property (
      (local_crit_q || remote_crit_q) |=> !critical_temp_output_n)
      else $error("Critical pin missed a trip.");

   only_flags_alert_a: assert property (
      (flags_q == 8'h00 && !role_crit) |=> shared_out_n)
      else $error("Interrupt pin asserted with no latched flag.");

   standby_limit_a: assert property (
      (standby && limit_wr && hit[tmon_pkg::ST_REM_HI_BIT]) |=> flags_q[tmon_pkg::ST_REM_HI_BIT])
      else $error("Standby limit write did not update the flags.");

   reserved_zero_a: assert property (
      (reg_rd && reg_addr == tmon_pkg::CONFIG_RD_ADDR) |=> reg_rdata[3] == 1'b0
      && reg_rdata[1:0] == 2'h0)
      else $error("Reserved configuration bits read non-zero.");
endmodule : temp_monitor_control_status_regs

// File: dv/fe_model.sv
// Purpose: Behavioural conversion front end that answers conversion requests.
// Assumes: One request at a time; the latency comes from the bench.
// Notes: Readings are valid only in the done cycle and show inverted values otherwise.
`timescale 1ns/100ps
module fe_model (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Request and bench-set values.
   input wire logic conv_start,
   input wire logic [7:0] lat,
   input wire logic [7:0] loc,
   input wire logic [7:0] rem,
   input wire logic opn,
   // Answer toward the register bank.
   output logic conv_done,
   output logic [7:0] local_temp,
   output logic [7:0] remote_temp,
   output logic remote_open
);
   logic [7:0] cnt_q; // Cycles left in the running conversion.
   logic run_q; // High while a conversion is in flight.

   // Counts the latency down and pulses done once, so a slow answer is possible too.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (conv_start) begin
            run_q <= 1'b1;
            cnt_q <= lat;
         end else if (run_q && cnt_q <= 8'h01) begin
            run_q <= 1'b0;
            conv_done <= 1'b1;
         end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   // Outside the done cycle the values are inverted, so a stale sample shows up.
   assign local_temp = conv_done ? loc : ~loc;
   assign remote_temp = conv_done ? rem : ~rem;
   assign remote_open = conv_done ? opn : ~opn;
endmodule : fe_model

// File: dv/tb.sv
// Purpose: Register-level test of the temperature monitor register bank.
// Assumes: Tick shortened to 4 cycles, so rate code 1010 gives 108 cycles.
// Notes: Flags are read right after a conversion, well before the next one.
`timescale 1ns/100ps
module tb;
   logic core_clk, nrst, reg_wr, reg_rd, limit_wr, opn, conv_start, conv_done, remote_open;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, lat, loc, rem, lhi, llo, rhi, rlo, lcr, rcr;
   logic [7:0] local_temp, remote_temp;
   logic beta_disable, range_extended, scl_timeout_en, sda_timeout_en;
   logic critical_temp_output_n, shared_out_n;
   int n_fail = 0; // Mismatches seen.
   int tests_run = 0; // Comparisons made.
   int k; // Wait counter.
   logic [7:0] cs [3][4] = '{'{8'h05, 8'h60, 8'h00, 8'h30}, '{8'h20, 8'h05, 8'h01, 8'h0c},
                             '{8'h20, 8'h20, 8'h00, 8'h00}};

   temp_monitor_control_status_regs #(.TICK_CYCLES(4)) uut (.core_clk(core_clk),
      .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_done(conv_done), .local_temp(local_temp), .remote_temp(remote_temp),
      .remote_open(remote_open), .beta_disable(beta_disable),
      .range_extended(range_extended), .local_high_lim(lhi), .local_low_lim(llo),
      .remote_high_lim(rhi), .remote_low_lim(rlo), .local_crit_lim(lcr),
      .remote_crit_lim(rcr), .limit_wr(limit_wr), .scl_timeout_en(scl_timeout_en),
      .sda_timeout_en(sda_timeout_en), .critical_temp_output_n(critical_temp_output_n),
      .shared_out_n(shared_out_n));
   fe_model fe (.core_clk(core_clk), .nrst(nrst), .conv_start(conv_start), .lat(lat),
      .loc(loc), .rem(rem), .opn(opn), .conv_done(conv_done), .local_temp(local_temp),
      .remote_temp(remote_temp), .remote_open(remote_open));

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One write strobe; the bus holds address and data through the sampling edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One read strobe; the data is taken a cycle late, as it stands until the next read.
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1 chk(reg_rdata, exp);
   endtask : rdc

   // Bounded waits; a missing event shows up as a mismatch.
   task automatic wait_sig(input bit done);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while ((done ? conv_done : conv_start) !== 1'b1 && k < 1200);
      chk({7'h0, done ? conv_done : conv_start}, 8'h01);
      if (done) repeat (3) @(posedge core_clk);
      #1;
   endtask : wait_sig

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // Free-running 50 ns clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Cuts a hang short; the full run needs some 2000 cycles.
   initial begin
      #(20000 * 50);
      n_fail++;
      end_of_test();
   end

   // Main sequence.
   initial begin
      nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; limit_wr = 1'b0; opn = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00; lat = 8'h28; loc = 8'h60; rem = 8'h20;
      lhi = 8'h55; llo = 8'h10; rhi = 8'h55; rlo = 8'h10; lcr = 8'h70; rcr = 8'h70;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      rdc(8'h03, 8'h00);
      rdc(8'h04, 8'h06);
      rdc(8'h22, 8'h01);
      rdc(8'h02, 8'h00);
      rdc(8'h55, 8'h00);
      // Every writable bit set; reserved bits must stay zero.
      wr(8'h09, 8'hff);
      wr(8'h0a, 8'hff);
      wr(8'h22, 8'hff);
      wr(8'h03, 8'h00);
      rdc(8'h03, 8'hf4);
      rdc(8'h04, 8'h0f);
      rdc(8'h22, 8'hcf);
      chk({6'h0, beta_disable, range_extended}, 8'h03);
      chk({6'h0, scl_timeout_en, sda_timeout_en}, 8'h03);
      wr(8'h22, 8'h00);
      wr(8'h0a, 8'h0a);
      wr(8'h09, 8'h00);
      rdc(8'h22, 8'h00);
      chk({6'h0, scl_timeout_en, sda_timeout_en}, 8'h00);
      chk({6'h0, beta_disable, range_extended}, 8'h00);
      // Slow conversion: busy shows, then the local high flag latches and clears.
      wait_sig(1'b0);
      rdc(8'h02, 8'h80);
      wait_sig(1'b1);
      chk({7'h0, shared_out_n}, 8'h00);
      rdc(8'h02, 8'h40);
      rdc(8'h02, 8'h00);
      chk({7'h0, shared_out_n}, 8'h01);
      lat <= 8'h01;
      // Masked interrupt stays quiet while the flag still latches.
      wr(8'h09, 8'h80);
      wait_sig(1'b1);
      chk({7'h0, shared_out_n}, 8'h01);
      rdc(8'h02, 8'h40);
      // Second critical role, local reading over its critical limit.
      loc <= 8'h80;
      wr(8'h09, 8'h20);
      wait_sig(1'b1);
      chk({6'h0, critical_temp_output_n, shared_out_n}, 8'h00);
      rdc(8'h02, 8'h41);
      loc <= 8'h20;
      wr(8'h09, 8'h00);
      wait_sig(1'b1);
      chk({6'h0, critical_temp_output_n, shared_out_n}, 8'h03);
      rdc(8'h02, 8'h00);
      // Code 1010 with a 4-cycle tick: successive requests lie 27 * 4 cycles apart.
      wait_sig(1'b0);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (conv_start !== 1'b1 && k < 200);
      chk(8'(k), 8'h6c);
      // Let the conversion just requested finish before the queue depth changes.
      wait_sig(1'b1);
      // Three consecutive out-of-limit conversions are needed for code 011x.
      wr(8'h22, 8'h06);
      loc <= 8'h60;
      for (int i = 0; i < 3; i++) begin
         wait_sig(1'b1);
         rdc(8'h02, (i == 2) ? 8'h40 : 8'h00);
      end
      wr(8'h22, 8'h00);
      // Remote, low and open flags from a table of readings.
      for (int i = 0; i < 3; i++) begin
         loc <= cs[i][0];
         rem <= cs[i][1];
         opn <= cs[i][2][0];
         wait_sig(1'b1);
         wait_sig(1'b1);
         rdc(8'h02, cs[i][3]);
      end
      // Standby: no requests, but a lowered limit re-evaluates the stored readings.
      wr(8'h09, 8'h40);
      rdc(8'h03, 8'h40);
      k = 0;
      repeat (300) begin
         @(posedge core_clk);
         #1 k += int'(conv_start);
      end
      chk(8'(k), 8'h00);
      rdc(8'h02, 8'h00);
      @(posedge core_clk);
      lhi <= 8'h10;
      rhi <= 8'h10;
      limit_wr <= 1'b1;
      @(posedge core_clk);
      limit_wr <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk({7'h0, shared_out_n}, 8'h00);
      rdc(8'h02, 8'h50);
      end_of_test();
   end
endmodule : tb
